// *** logic/activity_monitor_config_enable.sv ***
// Overview of operation
// [RULE1] config top field reads group count minus one, fixed at one
// [RULE2] config halt-on-debug support bit always reads one
// [RULE3] config counter-size field reads all ones for 64-bit counters
// [RULE4] config low byte returns printed counter-count constant 0x06
// [RULE5] group config auxiliary counter count reads three
// [RULE6] group config architected counter count reads four
// [RULE7] first clear register: bits 3:0 per counter, upper bits zero, ignore writes
// [RULE8] second clear register: bits 2:0 per counter, upper bits zero, ignore writes
// [RULE9] clear register bit reads one when counter enabled
// [RULE10] writing one to a clear bit disables; zero leaves it unchanged
// [RULE11] debugger reads config register at 0xE00, read-only
// [RULE12] debugger reads group config at 0xCE0, read-only
// [RULE13] debugger reads clear registers at 0xC20 and 0xC24, read-only
// [RULE14] bank decodes at 3,3,c15 with its documented CRm and op2
// [RULE15] every register reachable from all four levels
// [RULE16] top-level trap bit traps all lower-level accesses to top level
// [RULE17] hyp trap bit traps non-secure kernel and user accesses to hyp
// [RULE18] trap bit sits at bit 30; old monitor enable bits read zero
// [RULE19] writing one to a set bit enables; set and clear share state
// [RULE20] global halt-on-debug stops counting while core halted
// [RULE21] all counter enables read zero after warm reset
`timescale 1ns/1ps
`default_nettype none

module activity_monitor_config_enable (
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    input  wire logic                      clkEn,
    input  wire logic                      sysValid,
    input  wire logic                      sysWrite,
    input  wire amu_cfg_pkg::sysreg_s      sysAddr,
    input  wire logic [31:0]               sysWdata,
    input  wire amu_cfg_pkg::level_e       sysLevel,
    input  wire logic                      sysNonSecure,
    input  wire logic [31:0]               topLevelAuxControl,
    input  wire logic [31:0]               hypLevelAuxControl,
    input  wire logic                      dbgValid,
    input  wire logic [11:0]               dbgAddr,
    input  wire logic                      coreHalted,
    output logic                           sysReady,
    output logic [31:0]                    sysRdata,
    output logic                           sysTrapTop,
    output logic                           sysTrapHyp,
    output logic                           sysUndef,
    output logic                           dbgReady,
    output logic [31:0]                    dbgRdata,
    output logic                           dbgError,
    output logic [3:0]                     archCountEnable,
    output logic [2:0]                     auxCountEnable
);

    // ----------------------------------------------------------------
    // reset synchroniser
    // ----------------------------------------------------------------
    logic rstMeta;
    logic rstSync;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // ----------------------------------------------------------------
    // constant identification words
    // ----------------------------------------------------------------
    logic [31:0] monitorConfig;
    logic [31:0] counterGroupConfig;

    localparam int CFG_NCG_LSB_P  = amu_cfg_pkg::CFG_NCG_LSB;
    localparam int CFG_SIZE_LSB_P = amu_cfg_pkg::CFG_SIZE_LSB;
    localparam int GRP_AUX_LSB_P  = amu_cfg_pkg::GRP_AUX_LSB;

    always_comb begin
        monitorConfig = 32'h0000_0000;
        monitorConfig[CFG_NCG_LSB_P +: 4] = amu_cfg_pkg::CFG_NCG;            // RULE1
        monitorConfig[amu_cfg_pkg::CFG_HALT_ON_DEBUG_BIT] = 1'b1;                   // RULE2
        monitorConfig[CFG_SIZE_LSB_P +: 6] = amu_cfg_pkg::CFG_SIZE;        // RULE3
        monitorConfig[7:0] = amu_cfg_pkg::CFG_N;                           // RULE4
        counterGroupConfig = 32'h0000_0000;
        counterGroupConfig[GRP_AUX_LSB_P +: 8] = amu_cfg_pkg::GRP_AUX_NC;  // RULE5
        counterGroupConfig[7:0] = amu_cfg_pkg::GRP_ARCH_NC;                // RULE6
    end

    // ----------------------------------------------------------------
    // system register decode and trap check
    // ----------------------------------------------------------------
    logic bankHit;
    logic hitCtrl;
    logic hitCfg;
    logic hitGroup;
    logic hitClr0;
    logic hitSet0;
    logic hitClr1;
    logic hitSet1;
    logic trapTop;
    logic trapHyp;
    logic doAccess;

    always_comb begin
        bankHit  = (sysAddr.op0 == amu_cfg_pkg::SYS_OP0) && (sysAddr.op1 == amu_cfg_pkg::SYS_OP1)
                   && (sysAddr.crn == amu_cfg_pkg::SYS_CRN);                                  // RULE14
        hitCtrl  = bankHit && sysAddr.crm == amu_cfg_pkg::CRM_CFG && sysAddr.op2 == amu_cfg_pkg::OP2_CTRL;
        hitCfg   = bankHit && sysAddr.crm == amu_cfg_pkg::CRM_CFG && sysAddr.op2 == amu_cfg_pkg::OP2_CFG;
        hitGroup = bankHit && sysAddr.crm == amu_cfg_pkg::CRM_CFG && sysAddr.op2 == amu_cfg_pkg::OP2_GROUP;
        hitClr0  = bankHit && sysAddr.crm == amu_cfg_pkg::CRM_CFG && sysAddr.op2 == amu_cfg_pkg::OP2_CLR0;
        hitSet0  = bankHit && sysAddr.crm == amu_cfg_pkg::CRM_CFG && sysAddr.op2 == amu_cfg_pkg::OP2_SET0;
        hitClr1  = bankHit && sysAddr.crm == amu_cfg_pkg::CRM_CLR1 && sysAddr.op2 == amu_cfg_pkg::OP2_CLR1;
        hitSet1  = bankHit && sysAddr.crm == amu_cfg_pkg::CRM_CLR1 && sysAddr.op2 == amu_cfg_pkg::OP2_SET1;
        // top-level trap wins over the hyp trap; EL3 itself is never trapped
        trapTop  = topLevelAuxControl[amu_cfg_pkg::TRAP_BIT] && (sysLevel != amu_cfg_pkg::EL3);     // RULE16 RULE18
        trapHyp  = !trapTop && hypLevelAuxControl[amu_cfg_pkg::TRAP_BIT] && sysNonSecure
                   && (sysLevel == amu_cfg_pkg::EL0 || sysLevel == amu_cfg_pkg::EL1);               // RULE17 RULE18
        doAccess = sysValid && !trapTop && !trapHyp;                                                // RULE15
    end

    // ----------------------------------------------------------------
    // enable state and global control
    // ----------------------------------------------------------------
    logic [3:0] archEn;
    logic [2:0] auxEn;
    logic       haltOnDebug;
    logic [3:0] next_archEn;
    logic [2:0] next_auxEn;

    always_comb begin
        next_archEn = archEn;
        next_auxEn  = auxEn;
        if (doAccess && sysWrite) begin
            if (hitClr0)
                next_archEn = archEn & ~sysWdata[3:0];                     // RULE7 RULE10
            if (hitSet0)
                next_archEn = archEn | sysWdata[3:0];                      // RULE19
            if (hitClr1)
                next_auxEn = auxEn & ~sysWdata[2:0];                       // RULE8 RULE10
            if (hitSet1)
                next_auxEn = auxEn | sysWdata[2:0];                        // RULE19
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            archEn <= amu_cfg_pkg::ARCH_EN_RST;                            // RULE21
            auxEn  <= amu_cfg_pkg::AUX_EN_RST;                             // RULE21
        end else if (clkEn) begin
            archEn <= next_archEn;
            auxEn  <= next_auxEn;
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            haltOnDebug <= 1'b0;
        end else if (clkEn && doAccess && sysWrite && hitCtrl) begin
            haltOnDebug <= sysWdata[amu_cfg_pkg::CTRL_HALT_ON_DEBUG_BIT];
        end
    end

    // counting permitted only when enabled and not frozen by debug halt
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            archCountEnable <= 4'h0;
            auxCountEnable  <= 3'h0;
        end else if (clkEn) begin
            archCountEnable <= (haltOnDebug && coreHalted) ? 4'h0 : next_archEn;  // RULE20
            auxCountEnable  <= (haltOnDebug && coreHalted) ? 3'h0 : next_auxEn;   // RULE20
        end
    end

    // ----------------------------------------------------------------
    // system register answer, one cycle after the request
    // ----------------------------------------------------------------
    logic [31:0] sysMux;
    logic        sysHit;

    always_comb begin
        sysHit = 1'b1;
        sysMux = 32'h0000_0000;
        if (hitCfg)
            sysMux = monitorConfig;
        else if (hitGroup)
            sysMux = counterGroupConfig;
        else if (hitClr0 || hitSet0)
            sysMux = {28'h0000000, archEn};                                // RULE7 RULE9
        else if (hitClr1 || hitSet1)
            sysMux = {29'h0, auxEn};                                       // RULE8 RULE9
        else if (hitCtrl)
            sysMux = {21'h0, haltOnDebug, 10'h0};
        else
            sysHit = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            sysReady   <= 1'b0;
            sysRdata   <= 32'h0000_0000;
            sysTrapTop <= 1'b0;
            sysTrapHyp <= 1'b0;
            sysUndef   <= 1'b0;
        end else if (clkEn) begin
            sysReady   <= sysValid;
            sysTrapTop <= sysValid && trapTop;                             // RULE16
            sysTrapHyp <= sysValid && trapHyp;                             // RULE17
            sysUndef   <= doAccess && !sysHit;
            sysRdata   <= (doAccess && !sysWrite && sysHit) ? sysMux : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // external debug read port: read-only, no write path exists
    // ----------------------------------------------------------------
    logic [31:0] dbgMux;
    logic        dbgHit;

    always_comb begin
        dbgHit = 1'b1;
        dbgMux = 32'h0000_0000;
        if (dbgAddr == amu_cfg_pkg::DBG_CFG)
            dbgMux = monitorConfig;                                        // RULE11
        else if (dbgAddr == amu_cfg_pkg::DBG_GROUP)
            dbgMux = counterGroupConfig;                                   // RULE12
        else if (dbgAddr == amu_cfg_pkg::DBG_CLR0 || dbgAddr == amu_cfg_pkg::DBG_SET0)
            dbgMux = {28'h0000000, archEn};                                // RULE13
        else if (dbgAddr == amu_cfg_pkg::DBG_CLR1 || dbgAddr == amu_cfg_pkg::DBG_SET1)
            dbgMux = {29'h0, auxEn};                                       // RULE13
        else if (dbgAddr == amu_cfg_pkg::DBG_CTRL)
            dbgMux = {21'h0, haltOnDebug, 10'h0};
        else
            dbgHit = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            dbgReady <= 1'b0;
            dbgRdata <= 32'h0000_0000;
            dbgError <= 1'b0;
        end else if (clkEn) begin
            dbgReady <= dbgValid;
            dbgError <= dbgValid && !dbgHit;
            dbgRdata <= (dbgValid && dbgHit) ? dbgMux : 32'h0000_0000;
        end
    end

endmodule

`default_nettype wire

// *** logic/amu_cfg_pkg.sv ***
package amu_cfg_pkg;

    // ----------------------------------------------------------------
    // system register coordinates (op0, op1, CRn fixed for the bank)
    // ----------------------------------------------------------------
    localparam logic [1:0] SYS_OP0            = 2'h3;
    localparam logic [2:0] SYS_OP1            = 3'h3;
    localparam logic [3:0] SYS_CRN            = 4'hF;
    localparam logic [3:0] CRM_CFG            = 4'h2;
    localparam logic [3:0] CRM_CLR1           = 4'h3;
    localparam logic [2:0] OP2_CTRL           = 3'h0;
    localparam logic [2:0] OP2_CFG            = 3'h1;
    localparam logic [2:0] OP2_GROUP          = 3'h2;
    localparam logic [2:0] OP2_CLR0           = 3'h4;
    localparam logic [2:0] OP2_SET0           = 3'h5;
    localparam logic [2:0] OP2_CLR1           = 3'h0;
    localparam logic [2:0] OP2_SET1           = 3'h1;

    // ----------------------------------------------------------------
    // debug interface offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] DBG_SET0          = 12'hC00;
    localparam logic [11:0] DBG_SET1          = 12'hC04;
    localparam logic [11:0] DBG_CLR0          = 12'hC20;
    localparam logic [11:0] DBG_CLR1          = 12'hC24;
    localparam logic [11:0] DBG_GROUP         = 12'hCE0;
    localparam logic [11:0] DBG_CFG           = 12'hE00;
    localparam logic [11:0] DBG_CTRL          = 12'hE04;

    // ----------------------------------------------------------------
    // identification field values and positions
    // ----------------------------------------------------------------
    localparam int          CFG_NCG_LSB       = 28;
    localparam logic [3:0]  CFG_NCG          = 4'h1;
    localparam int          CFG_HALT_ON_DEBUG_BIT     = 24;
    localparam int          CFG_SIZE_LSB     = 8;
    localparam logic [5:0]  CFG_SIZE         = 6'h3F;
    localparam logic [7:0]  CFG_N            = 8'h06;
    localparam int          GRP_AUX_LSB      = 8;
    localparam logic [7:0]  GRP_AUX_NC       = 8'h03;
    localparam logic [7:0]  GRP_ARCH_NC      = 8'h04;
    localparam int          CTRL_HALT_ON_DEBUG_BIT    = 10;
    localparam int          TRAP_BIT         = 30;
    localparam int          ARCH_CNT         = 4;
    localparam int          AUX_CNT          = 3;
    localparam logic [ARCH_CNT-1:0] ARCH_EN_RST = 4'h0;
    localparam logic [AUX_CNT-1:0]  AUX_EN_RST  = 3'h0;

    typedef enum logic [1:0] {
        EL0 = 2'b00,
        EL1 = 2'b01,
        EL2 = 2'b10,
        EL3 = 2'b11
    } level_e;

    typedef struct packed {
        logic [1:0] op0;
        logic [2:0] op1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
    } sysreg_s;

endpackage

// *** verif/amu_cfg_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module amu_cfg_assertions (
    input wire logic                 clk_sys,
    input wire logic                 nrst,
    input wire logic                 clkEn,
    input wire logic                 sysValid,
    input wire logic                 sysWrite,
    input wire amu_cfg_pkg::sysreg_s sysAddr,
    input wire logic [31:0]          sysWdata,
    input wire amu_cfg_pkg::level_e  sysLevel,
    input wire logic                 sysNonSecure,
    input wire logic [31:0]          topLevelAuxControl,
    input wire logic [31:0]          hypLevelAuxControl,
    input wire logic                 dbgValid,
    input wire logic [11:0]          dbgAddr,
    input wire logic                 coreHalted,
    input wire logic                 sysReady,
    input wire logic [31:0]          sysRdata,
    input wire logic                 sysTrapTop,
    input wire logic                 sysTrapHyp,
    input wire logic [31:0]          dbgRdata,
    input wire logic                 dbgReady,
    input wire logic [3:0]           archCountEnable,
    input wire logic [2:0]           auxCountEnable
);
    logic acc, dbg, trapT, trapH;
    assign acc = clkEn && sysValid;
    assign dbg = clkEn && dbgValid;
    // top trap wins, so hyp trap is only expected when top is quiet
    assign trapT = topLevelAuxControl[30] && sysLevel != amu_cfg_pkg::EL3;
    assign trapH = !trapT && hypLevelAuxControl[30] && sysNonSecure && sysLevel < amu_cfg_pkg::EL2;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_sys_answer; acc |=> sysReady; endproperty
    a_sys_answer: assert property (p_sys_answer) else $error("no sys answer");
    property p_cfg_value; acc && !sysWrite && sysAddr == 16'hDF91 && !trapT && !trapH |=> sysRdata == 32'h11003F06; endproperty
    a_cfg_value: assert property (p_cfg_value) else $error("config value wrong");
    property p_dbg_cfg; dbg && dbgAddr == 12'hE00 |=> dbgRdata == 32'h11003F06; endproperty
    a_dbg_cfg: assert property (p_dbg_cfg) else $error("debug config wrong");
    property p_dbg_answer; dbg |=> dbgReady; endproperty
    a_dbg_answer: assert property (p_dbg_answer) else $error("no debug answer");
    property p_dbg_group; dbg && dbgAddr == 12'hCE0 |=> dbgRdata == 32'h00000304; endproperty
    a_dbg_group: assert property (p_dbg_group) else $error("debug group wrong");
    property p_trap_top; acc && trapT |=> sysTrapTop && !sysTrapHyp && sysRdata == 32'h0; endproperty
    a_trap_top: assert property (p_trap_top) else $error("top trap wrong");
    property p_trap_hyp; acc && trapH |=> sysTrapHyp && !sysTrapTop; endproperty
    a_trap_hyp: assert property (p_trap_hyp) else $error("hyp trap wrong");
    property p_clr_write; acc && sysWrite && sysAddr == 16'hDF94 && !trapT && !trapH && !coreHalted
        |=> coreHalted || archCountEnable == ($past(archCountEnable) & ~$past(sysWdata[3:0])); endproperty
    a_clr_write: assert property (p_clr_write) else $error("clear write wrong");
    property p_reset_clear; $rose(nrst) |-> archCountEnable == 4'h0 && auxCountEnable == 3'h0; endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("enables not clear");
endmodule
bind activity_monitor_config_enable amu_cfg_assertions chk_u (
    .clk_sys, .nrst, .clkEn, .sysValid, .sysWrite, .sysAddr, .sysWdata, .sysLevel, .sysNonSecure,
    .topLevelAuxControl, .hypLevelAuxControl, .dbgValid, .dbgAddr, .coreHalted, .sysReady, .sysRdata,
    .sysTrapTop, .sysTrapHyp, .dbgRdata, .dbgReady, .archCountEnable, .auxCountEnable
);
`default_nettype wire

// *** verif/debugger_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module debugger_model (
    input  wire logic        clk_sys,
    input  wire logic        go,
    input  wire logic [11:0] goAddr,
    input  wire logic        dbgReady,
    input  wire logic [31:0] dbgRdata,
    input  wire logic        dbgError,
    output logic             dbgValid,
    output logic [11:0]      dbgAddr,
    output logic [31:0]      rdData,
    output logic             rdErr,
    output logic             done
);
    initial begin
        dbgValid = 1'b0;
        dbgAddr = 12'h000;
        done = 1'b0;
    end
    // reads only: the debug path offers no write
    always @(posedge clk_sys) begin
        dbgValid <= go && !dbgValid;
        // offset is not held after the read, so a stale value cannot pass
        dbgAddr <= (go && !dbgValid) ? goAddr : ~dbgAddr;
        done <= dbgReady;
        if (dbgReady) begin
            rdData <= dbgRdata;
            rdErr <= dbgError;
        end
    end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [3:0] crm, op2, wr;
        logic [31:0] wd;
        logic [3:0] lvl, ns, top, hyp;
        logic [31:0] rd;
        logic [3:0] fl;
    } acc_s;
    logic clk_sys, sysReady, sysTrapTop, sysTrapHyp, sysUndef, dbgReady, dbgError, dbgValid, done, rdErr;
    logic nrst = 1'b0, clkEn = 1'b1, sysValid = 1'b0, sysWrite = 1'b0, sysNonSecure = 1'b0;
    logic coreHalted = 1'b0, go = 1'b0;
    logic [11:0] goAddr = 12'h000, dbgAddr;
    logic [31:0] sysWdata = 32'h0, topCtl = 32'h0, hypCtl = 32'h0, sysRdata, dbgRdata, rdData;
    amu_cfg_pkg::sysreg_s sysAddr = 16'h0;
    amu_cfg_pkg::level_e sysLevel = amu_cfg_pkg::EL0;
    logic [3:0] archCountEnable;
    logic [2:0] auxCountEnable;
    int mismatches = 0;
    int n_compared = 0;
    acc_s rows [23];
    logic [11:0] dA [8] = '{12'hC20, 12'hC24, 12'hCE0, 12'hE00, 12'hC00, 12'hC04, 12'hE04, 12'h800};
    logic [31:0] dE [8] = '{32'hA, 32'h5, 32'h304, 32'h11003F06, 32'hA, 32'h5, 32'h0, 32'h0};

    activity_monitor_config_enable dut_u (
        .clk_sys, .nrst, .clkEn, .sysValid, .sysWrite, .sysAddr, .sysWdata, .sysLevel, .sysNonSecure,
        .topLevelAuxControl(topCtl), .hypLevelAuxControl(hypCtl), .dbgValid, .dbgAddr, .coreHalted,
        .sysReady, .sysRdata, .sysTrapTop, .sysTrapHyp, .sysUndef, .dbgReady, .dbgRdata, .dbgError,
        .archCountEnable, .auxCountEnable
    );
    debugger_model dbg_u (
        .clk_sys, .go, .goAddr, .dbgReady, .dbgRdata, .dbgError, .dbgValid, .dbgAddr, .rdData, .rdErr, .done
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one access per cycle; valid stays high between back-to-back calls, caller lowers it
    task automatic sys_acc(input acc_s r);
        sysAddr = '{2'h3, 3'h3, 4'hF, r.crm, r.op2[2:0]};
        sysWrite = r.wr[0];
        sysWdata = r.wd;
        sysLevel = amu_cfg_pkg::level_e'(r.lvl[1:0]);
        sysNonSecure = r.ns[0];
        topCtl = r.top[0] ? 32'h40000000 : 32'hBFFFFFFF;
        hypCtl = r.hyp[0] ? 32'h40000000 : 32'hBFFFFFFF;
        sysValid = 1'b1;
        @(negedge clk_sys);
        check("sysReady", {31'h0, sysReady}, 32'h1);
        check("sysRdata", sysRdata, r.rd);
        check("flags", {29'h0, sysTrapTop, sysTrapHyp, sysUndef}, {28'h0, r.fl});
    endtask

    task automatic dbg_read(input logic [11:0] a, input logic [31:0] e, input logic er);
        go = 1'b1;
        goAddr = a;
        @(negedge clk_sys);
        go = 1'b0;
        for (int i = 0; i < 8 && !done; i++) @(negedge clk_sys);
        if (done !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
        check("dbgRdata", rdData, e);
        check("dbgError", {31'h0, rdErr}, {31'h0, er});
    endtask

    initial begin
        rows = '{
            96'h2_5_1_0000000F_0_0_0_0_00000000_0, 96'h2_4_0_00000000_0_1_0_0_0000000F_0,
            96'h2_4_1_FFFFFFF5_1_1_0_0_00000000_0, 96'h2_4_0_00000000_2_0_0_0_0000000A_0,
            96'h3_1_1_FFFFFFFF_3_0_0_0_00000000_0, 96'h3_0_1_00000002_0_0_0_0_00000000_0,
            96'h3_0_0_00000000_1_0_0_0_00000005_0, 96'h2_1_0_00000000_0_1_0_0_11003F06_0,
            96'h2_1_1_00000000_3_0_0_0_00000000_0, 96'h2_1_0_00000000_2_0_0_0_11003F06_0,
            96'h2_2_0_00000000_1_0_0_0_00000304_0, 96'h2_2_1_FFFFFFFF_3_0_0_0_00000000_0,
            96'h2_2_0_00000000_3_1_0_0_00000304_0, 96'h2_4_0_00000000_2_0_1_0_00000000_4,
            96'h2_4_0_00000000_3_0_1_0_0000000A_0, 96'h3_0_0_00000000_1_1_0_1_00000000_2,
            96'h2_4_0_00000000_0_0_0_1_0000000A_0, 96'h2_4_0_00000000_2_1_0_1_0000000A_0,
            96'h3_0_0_00000000_0_1_1_1_00000000_4, 96'h2_4_1_0000000F_0_0_1_0_00000000_4,
            96'h2_4_0_00000000_1_0_0_0_0000000A_0, 96'h5_7_0_00000000_0_0_0_0_00000000_1,
            96'h2_0_1_00000400_0_0_0_0_00000000_0};
        repeat (10) @(negedge clk_sys);
        check("archEn", {28'h0, archCountEnable}, 32'h0);
        nrst = 1'b1;
        repeat (3) @(negedge clk_sys);
        foreach (rows[i]) sys_acc(rows[i]);
        sysValid = 1'b0;
        check("archEn", {28'h0, archCountEnable}, 32'hA);
        check("auxEn", {29'h0, auxCountEnable}, 32'h5);
        coreHalted = 1'b1;
        @(negedge clk_sys);
        check("haltEn", {25'h0, auxCountEnable, archCountEnable}, 32'h0);
        coreHalted = 1'b0;
        sys_acc(96'h2_0_1_00000000_0_0_0_0_00000000_0);
        sysValid = 1'b0;
        coreHalted = 1'b1;
        @(negedge clk_sys);
        check("runEn", {28'h0, archCountEnable}, 32'hA);
        foreach (dA[i]) dbg_read(dA[i], dE[i], i == 7);
        nrst = 1'b0;
        @(negedge clk_sys);
        check("rstEn", {25'h0, auxCountEnable, archCountEnable}, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
